// *** psmon_defs.vh ***
`ifndef PSMON_DEFS_VH
`define PSMON_DEFS_VH

// Register offsets on the register port
`define PSMON_ADDR_W 12
`define PSMON_REG_CTRL 12'h270
`define PSMON_REG_PERIOD0 12'h271
`define PSMON_REG_PERIOD1 12'h272
`define PSMON_REG_PERIOD2 12'h273
`define PSMON_REG_HOLD0 12'h274
`define PSMON_REG_HOLD1 12'h275
`define PSMON_REG_SCE_A 12'h279
`define PSMON_REG_SCE_B 12'h27A
`define PSMON_REG_LSEL0 12'h559
`define PSMON_REG_LSEL1 12'h55A
`define PSMON_REG_LCFG 12'h58F

// Field positions
`define PSMON_CTRL_PEAK_EN 1
`define PSMON_SCE_B_BIT 1
`define PSMON_LCFG_CS_LO 6
`define PSMON_LCFG_CS_HI 7

// Reset values
`define PSMON_RST_BYTE 8'h00
`define PSMON_RST_PERIOD 24'h000000

// Frame layout
`define PSMON_FRAME_LEN 25
`define PSMON_SUBFRAME_LEN 5
`define PSMON_SUBFRAMES 5
`define PSMON_PAYLOAD_BITS 4
`define PSMON_CTRL_BITS 3

`endif

// *** psmon_peak.v ***
`default_nettype none

module psmon_peak #(
    parameter MAG_W = 13,
    parameter PER_W = 24,
    parameter IN_W = 16
) (
    input wire ref_clk, // System clock
    input wire reset, // Synchronous reset, active high
    input wire sample_en, // One pulse per decimated sample
    input wire signed [IN_W-1:0] sample_in, // Signed converter sample
    input wire enable, // Peak detection enable
    input wire [PER_W-1:0] period, // Programmed window length
    output reg [MAG_W-1:0] hold_value, // Last captured peak
    output reg hold_strobe // Pulse when hold_value updates
);

    reg [PER_W-1:0] timer;
    reg [MAG_W-1:0] run_peak;
    reg running;
    reg first;
    wire [IN_W-1:0] abs_full;
    wire [MAG_W-1:0] mag;
    wire [MAG_W-1:0] next_peak;

    // RL17: absolute then truncate
    assign abs_full = sample_in[IN_W-1] ? (~sample_in + {{(IN_W-1){1'b0}}, 1'b1}) : sample_in;
    // RL1: magnitude only, 13-bit result
    assign mag = abs_full[IN_W-1 -: MAG_W];
    // RL6: keep the larger; RL7: seed on window start
    assign next_peak = (first || mag > run_peak) ? mag : run_peak;

    always @(posedge ref_clk) begin
        hold_strobe <= 1'b0;
        if (reset) begin
            timer <= {PER_W{1'b0}};
            run_peak <= {MAG_W{1'b0}};
            running <= 1'b0;
            first <= 1'b1;
            hold_value <= {MAG_W{1'b0}};
        end else if (!enable) begin
            running <= 1'b0;
            first <= 1'b1;
        end else if (!running) begin
            // RL5: load period on enable
            timer <= period;
            running <= 1'b1;
            first <= 1'b1;
        end else if (sample_en) begin
            run_peak <= next_peak;
            first <= 1'b0;
            // RL8: transfer at count of one
            if (timer <= {{(PER_W-1){1'b0}}, 1'b1}) begin
                hold_value <= next_peak;
                hold_strobe <= 1'b1;
                // RL9: reload and reseed
                timer <= period;
                first <= 1'b1;
            end else begin
                timer <= timer - {{(PER_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

// *** psmon_frame.v ***
`default_nettype none
`include "psmon_defs.vh"

module psmon_frame #(
    parameter MAG_W = 13
) (
    input wire ref_clk, // System clock
    input wire reset, // Synchronous reset, active high
    input wire sample_en, // One pulse per decimated sample
    input wire load, // Pulse: new peak ready
    input wire [MAG_W-1:0] value, // Peak to send
    output reg ser_bit, // Serial bit for this sample
    output reg busy // Frame in flight
);

    reg [`PSMON_FRAME_LEN-1:0] shreg;
    reg [4:0] cnt;
    reg pending;
    reg [MAG_W-1:0] pend_val;
    wire [19:0] payload;
    wire [`PSMON_FRAME_LEN-1:0] frame;

    // RL18: unused payload zero-padded high
    assign payload = {{(20-MAG_W){1'b0}}, pend_val};

    // RL14: five subframes, MSB first; RL15: start bit leads each
    genvar g;
    generate
        for (g = 0; g < `PSMON_SUBFRAMES; g = g + 1) begin : g_sub
            assign frame[`PSMON_FRAME_LEN-1-g*`PSMON_SUBFRAME_LEN] = 1'b1;
            assign frame[`PSMON_FRAME_LEN-2-g*`PSMON_SUBFRAME_LEN -: `PSMON_PAYLOAD_BITS] =
                payload[19-g*`PSMON_PAYLOAD_BITS -: `PSMON_PAYLOAD_BITS];
        end
    endgenerate

    always @(posedge ref_clk) begin
        if (reset) begin
            shreg <= {`PSMON_FRAME_LEN{1'b0}};
            cnt <= 5'h00;
            pending <= 1'b0;
            pend_val <= {MAG_W{1'b0}};
            ser_bit <= 1'b0;
            busy <= 1'b0;
        end else begin
            if (load) begin
                pending <= 1'b1;
                pend_val <= value;
            end
            if (sample_en) begin
                if (cnt != 5'h00) begin
                    ser_bit <= shreg[`PSMON_FRAME_LEN-1];
                    shreg <= {shreg[`PSMON_FRAME_LEN-2:0], 1'b0};
                    cnt <= cnt - 5'h01;
                end else if (pending && !load) begin
                    // Idle line is zero, so a start bit marks a frame
                    ser_bit <= frame[`PSMON_FRAME_LEN-1];
                    shreg <= {frame[`PSMON_FRAME_LEN-2:0], 1'b0};
                    cnt <= 5'h18;
                    pending <= 1'b0;
                end else begin
                    ser_bit <= 1'b0;
                end
            end
            busy <= (cnt != 5'h00) || pending;
        end
    end

endmodule

`default_nettype wire

// *** psmon_top.v ***
`default_nettype none
`include "psmon_defs.vh"

// Summary of operation
// RL1: Track only sample magnitude; keep window's largest at 13-bit resolution.
// RL2: Window length is one global 24-bit value counted in samples.
// RL3: Peak detection runs while control register peak_monitor_control bit 1 is set.
// RL4: Software writes the period before setting the enable.
// RL5: Enabling loads the period into a timer decremented per decimated sample.
// RL6: Each sample is compared with a hidden running peak; larger is kept.
// RL7: Window start seeds the running peak with the current sample magnitude.
// RL8: At timer count one the running peak moves to the readable holding register.
// RL9: Then the timer reloads and the peak reseeds from the next window's first sample.
// RL10: Side channel needs side_channel_enable_a bits 1:0 and side_channel_enable_b bit 1 set.
// RL11: Up to three control bits per sample; side channel uses exactly one.
// RL12: Control bits fill from the most significant position downward.
// RL13: Software programs link_control_bit_select_0, link_control_bit_select_1 and link_control_bit_config to route the side channel.
// RL13 in the code: both select registers are ignored; only a nonzero link_control_bit_config bits 7:6 turns on the one control bit.
// RL14: Peak sent as 25-bit frame of five 5-bit subframes, MSB first.
// RL15: Every subframe begins with a start bit for receiver validation.
// RL16: The receiver extracts control bits and reassembles the statistics.
// RL17: Magnitude is absolute value of the signed sample truncated to 13 bits.
// RL18: Subframe start bit is one, then four payload bits, spare payload zero.
module psmon_top #(
    parameter IN_W = 16,
    parameter MAG_W = 13,
    parameter PER_W = 24
) (
    input wire ref_clk, // System clock, 100 MHz
    input wire reset, // Synchronous reset, active high
    input wire sample_en, // Decimated sample clock enable
    input wire [IN_W-1:0] sample_in, // Signed converter sample
    input wire reg_wr, // Register write strobe
    input wire reg_rd, // Register read strobe
    input wire [`PSMON_ADDR_W-1:0] reg_addr, // Register address
    input wire [7:0] reg_wdata, // Register write data
    output reg [7:0] reg_rdata, // Register read data
    output reg [`PSMON_CTRL_BITS-1:0] ctrl_bits, // Control bits for current sample, MSB first
    output reg [IN_W-1:0] sample_out // Sample registered on sample_en, one cycle ahead of its ctrl_bits
);

    reg [7:0] peak_monitor_control;
    reg [7:0] side_channel_enable_a;
    reg [7:0] side_channel_enable_b;
    reg [7:0] link_control_bit_select_0;
    reg [7:0] link_control_bit_select_1;
    reg [7:0] link_control_bit_config;
    reg [PER_W-1:0] monitor_period;
    wire [MAG_W-1:0] hold_value;
    wire hold_strobe;
    wire ser_bit;
    wire peak_en;
    wire side_en;
    wire [1:0] cs_count;
    reg [7:0] next_rdata;
    reg [`PSMON_CTRL_BITS-1:0] next_ctrl;
    wire [15:0] hold_pad;

    // RL3: peak detection enable bit
    assign peak_en = peak_monitor_control[`PSMON_CTRL_PEAK_EN];
    // RL10: both enable registers gate the side channel
    assign side_en = (side_channel_enable_a[1:0] == 2'b11) && side_channel_enable_b[`PSMON_SCE_B_BIT];
    // RL13: control-bit count comes from link configuration
    assign cs_count = link_control_bit_config[`PSMON_LCFG_CS_HI:`PSMON_LCFG_CS_LO];
    assign hold_pad = {{(16-MAG_W){1'b0}}, hold_value};

    // RL4: period is sampled when enabling and again at every window reload
    psmon_peak #(
        .MAG_W(MAG_W),
        .PER_W(PER_W),
        .IN_W(IN_W)
    ) u_peak (
        .ref_clk(ref_clk),
        .reset(reset),
        .sample_en(sample_en),
        .sample_in(sample_in),
        .enable(peak_en),
        .period(monitor_period),
        .hold_value(hold_value),
        .hold_strobe(hold_strobe)
    );

    psmon_frame #(
        .MAG_W(MAG_W)
    ) u_frame (
        .ref_clk(ref_clk),
        .reset(reset),
        .sample_en(sample_en),
        .load(hold_strobe & side_en),
        .value(hold_value),
        .ser_bit(ser_bit),
        .busy()
    );

    always @(posedge ref_clk) begin
        if (reset) begin
            peak_monitor_control <= `PSMON_RST_BYTE;
            side_channel_enable_a <= `PSMON_RST_BYTE;
            side_channel_enable_b <= `PSMON_RST_BYTE;
            link_control_bit_select_0 <= `PSMON_RST_BYTE;
            link_control_bit_select_1 <= `PSMON_RST_BYTE;
            link_control_bit_config <= `PSMON_RST_BYTE;
            monitor_period <= `PSMON_RST_PERIOD;
        end else if (reg_wr) begin
            case (reg_addr)
                `PSMON_REG_CTRL: peak_monitor_control <= reg_wdata;
                // RL2: one global 24-bit period in three bytes
                `PSMON_REG_PERIOD0: monitor_period[7:0] <= reg_wdata;
                `PSMON_REG_PERIOD1: monitor_period[15:8] <= reg_wdata;
                `PSMON_REG_PERIOD2: monitor_period[23:16] <= reg_wdata;
                `PSMON_REG_SCE_A: side_channel_enable_a <= reg_wdata;
                `PSMON_REG_SCE_B: side_channel_enable_b <= reg_wdata;
                `PSMON_REG_LSEL0: link_control_bit_select_0 <= reg_wdata;
                `PSMON_REG_LSEL1: link_control_bit_select_1 <= reg_wdata;
                `PSMON_REG_LCFG: link_control_bit_config <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    always @* begin
        case (reg_addr)
            `PSMON_REG_CTRL: next_rdata = peak_monitor_control;
            `PSMON_REG_PERIOD0: next_rdata = monitor_period[7:0];
            `PSMON_REG_PERIOD1: next_rdata = monitor_period[15:8];
            `PSMON_REG_PERIOD2: next_rdata = monitor_period[23:16];
            // RL8: holding register readable
            `PSMON_REG_HOLD0: next_rdata = hold_pad[7:0];
            `PSMON_REG_HOLD1: next_rdata = hold_pad[15:8];
            `PSMON_REG_SCE_A: next_rdata = side_channel_enable_a;
            `PSMON_REG_SCE_B: next_rdata = side_channel_enable_b;
            `PSMON_REG_LSEL0: next_rdata = link_control_bit_select_0;
            `PSMON_REG_LSEL1: next_rdata = link_control_bit_select_1;
            `PSMON_REG_LCFG: next_rdata = link_control_bit_config;
            default: next_rdata = 8'h00;
        endcase
    end

    always @* begin
        next_ctrl = {`PSMON_CTRL_BITS{1'b0}};
        // RL11: one bit only; RL12: the most significant position
        if (side_en && cs_count != 2'b00) begin
            next_ctrl[`PSMON_CTRL_BITS-1] = ser_bit;
        end
    end

    // The serializer already advanced on this sample; ctrl_bits follows one cycle later
    always @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            ctrl_bits <= {`PSMON_CTRL_BITS{1'b0}};
            sample_out <= {IN_W{1'b0}};
        end else begin
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
            if (sample_en) begin
                sample_out <= sample_in;
            end
            ctrl_bits <= next_ctrl;
        end
    end

endmodule

`default_nettype wire

// *** psmon_monitor.sv ***
`default_nettype none
module psmon_monitor #(parameter IN_W = 16) (
    input wire logic ref_clk, // Clock
    input wire logic reset, // Sync reset
    input wire logic sample_en, // Sample strobe
    input wire logic [IN_W-1:0] sample_in, // Sample in
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [11:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic [2:0] ctrl_bits, // Control bits
    input wire logic [IN_W-1:0] sample_out // Aligned sample
);
    logic se_d;
    logic [4:0] pos;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Track bit position the way a receiver would, so frame fields can be judged
    always @(posedge ref_clk) begin
        if (reset) begin
            se_d <= 1'b0;
            pos <= 5'h00;
        end else begin
            se_d <= sample_en;
            if (se_d && (pos != 5'h00 || ctrl_bits[2]))
                pos <= (pos == 5'h18) ? 5'h00 : pos + 5'h01;
        end
    end
    chk_low_bits_zero: assert property (ctrl_bits[1:0] == 2'h0)
        else $error("unused control bits not zero");
    chk_sample_aligned: assert property (sample_en |=> sample_out == $past(sample_in))
        else $error("sample_out not aligned to sample");
    chk_bit_per_sample: assert property (!se_d |=> $stable(ctrl_bits))
        else $error("control bits moved without a sample");
    chk_start_bits: assert property (se_d && (pos inside {5'h05, 5'h0A, 5'h0F, 5'h14}) |-> ctrl_bits[2])
        else $error("subframe start bit missing");
    chk_pad_zero: assert property (se_d && (pos inside {[5'h01:5'h04], [5'h06:5'h08]}) |-> !ctrl_bits[2])
        else $error("spare payload bit not zero");
    chk_rdata_stands: assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[12'h270:12'h275], 12'h279, 12'h27A,
        12'h559, 12'h55A, 12'h58F}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_idle_after_reset: assert property (disable iff (1'b0) reset |=> ctrl_bits == 3'h0)
        else $error("control bits not idle after reset");
endmodule
bind psmon_top psmon_monitor #(.IN_W(IN_W)) psmon_monitor_inst (.ref_clk(ref_clk), .reset(reset),
    .sample_en(sample_en), .sample_in(sample_in), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ctrl_bits(ctrl_bits), .sample_out(sample_out));
`default_nettype wire

// *** psmon_rx_model.sv ***
`default_nettype none
module psmon_rx_model (
    input wire logic ref_clk, // Clock
    input wire logic reset, // Sync reset
    input wire logic sample_en, // Sample strobe
    input wire logic ser_in, // Top control bit
    output logic [12:0] rx_value, // Last peak received
    output logic [7:0] rx_count, // Frames received
    output logic rx_err // Bad start bit seen
);
    logic se_d;
    logic [4:0] pos;
    logic [23:0] sh;
    wire [24:0] f = {sh, ser_in};
    always @(posedge ref_clk) begin
        if (reset) begin
            se_d <= 1'b0;
            pos <= 5'h00;
            sh <= 24'h000000;
            rx_value <= 13'h0000;
            rx_count <= 8'h00;
            rx_err <= 1'b0;
        end else begin
            se_d <= sample_en;
            if (se_d && (pos != 5'h00 || ser_in)) begin
                sh <= f[23:0];
                pos <= pos + 5'h01;
                if (pos == 5'h18) begin
                    pos <= 5'h00;
                    rx_count <= rx_count + 8'h01;
                    rx_value <= {f[15], f[13:10], f[8:5], f[3:0]};
                    if (!(f[24] && f[19] && f[14] && f[9] && f[4]))
                        rx_err <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** psmon_top_tb_top.sv ***
`default_nettype none
module psmon_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic sample_en = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] sample_in = 16'h0000;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire [2:0] ctrl_bits;
    wire [15:0] sample_out;
    wire [12:0] rx_value;
    wire [7:0] rx_count;
    wire rx_err;
    int mismatches = 0;
    int n_tests = 0;
    logic [11:0] rw_regs [8] = '{12'h271, 12'h272, 12'h273, 12'h279, 12'h27A, 12'h559, 12'h55A, 12'h58F};
    always #5 ref_clk = ~ref_clk;
    psmon_top psmon_top_inst (.ref_clk(ref_clk), .reset(reset), .sample_en(sample_en), .sample_in(sample_in),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ctrl_bits(ctrl_bits), .sample_out(sample_out));
    psmon_rx_model psmon_rx_model_inst (.ref_clk(ref_clk), .reset(reset), .sample_en(sample_en),
        .ser_in(ctrl_bits[2]), .rx_value(rx_value), .rx_count(rx_count), .rx_err(rx_err));
    task close_out;
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    function logic [12:0] mag(input logic [15:0] x);
        return x[15] ? ((-x) >> 3) : (x >> 3);
    endfunction
    task tick;
        @(posedge ref_clk);
        #1;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick;
        reg_wr = 1'b0;
        tick;
    endtask
    // Result is read a cycle late so either answer edge is tolerated
    task rd(input logic [11:0] a, input logic [7:0] e);
        reg_rd = 1'b1;
        reg_addr = a;
        tick;
        reg_rd = 1'b0;
        tick;
        cmp("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    task hold(input logic [12:0] e);
        rd(12'h274, e[7:0]);
        rd(12'h275, {3'h0, e[12:8]});
    endtask
    task smp(input logic [15:0] x);
        sample_en = 1'b1;
        sample_in = x;
        tick;
        sample_en = 1'b0;
        tick;
    endtask
    task win(input logic [15:0] pk, input int at, input int n);
        for (int i = 0; i < n; i++)
            smp(i == at ? pk : (i[0] ? 16'hFFF8 : 16'h0010));
    endtask
    task t_reset;
        for (int i = 0; i < 8; i++)
            rd(rw_regs[i], 8'h00);
        for (int i = 0; i < 6; i++)
            rd(12'h270 + 12'(i), 8'h00);
    endtask
    task t_regs;
        for (int i = 0; i < 8; i++) begin
            wr(rw_regs[i], 8'h11 * 8'(i + 1));
            rd(rw_regs[i], 8'h11 * 8'(i + 1));
        end
        wr(12'h274, 8'h5A);
        rd(12'h274, 8'h00);
        wr(12'h300, 8'hFF);
        rd(12'h300, 8'h00);
    endtask
    task t_stream;
        wr(12'h271, 8'h1E);
        wr(12'h272, 8'h00);
        wr(12'h273, 8'h00);
        wr(12'h279, 8'h03);
        wr(12'h27A, 8'h02);
        wr(12'h58F, 8'h40);
        wr(12'h270, 8'h02);
        tick;
        win(16'h8010, 7, 30);
        hold(mag(16'h8010));
        win(16'h1238, 0, 30);
        hold(mag(16'h1238));
        cmp("rx_count", 16'h0001, {8'h00, rx_count});
        cmp("rx_value", {3'h0, mag(16'h8010)}, {3'h0, rx_value});
        win(16'hC000, 29, 30);
        hold(mag(16'hC000));
        cmp("rx_value", {3'h0, mag(16'h1238)}, {3'h0, rx_value});
        win(16'h0008, 0, 26);
        cmp("rx_count", 16'h0003, {8'h00, rx_count});
        cmp("rx_value", {3'h0, mag(16'hC000)}, {3'h0, rx_value});
        cmp("rx_err", 16'h0000, {15'h0000, rx_err});
    endtask
    task t_short;
        wr(12'h27A, 8'h00);
        wr(12'h270, 8'h00);
        wr(12'h271, 8'h01);
        wr(12'h270, 8'h02);
        rd(12'h270, 8'h02);
        smp(16'h7FF8);
        hold(mag(16'h7FF8));
        smp(16'hFFF0);
        hold(mag(16'hFFF0));
        win(16'h0100, 3, 30);
        cmp("rx_count", 16'h0003, {8'h00, rx_count});
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        t_reset;
        t_regs;
        t_stream;
        t_short;
        close_out;
    end
    // Cuts a hung run short; counts as a failure
    initial begin
        #500000;
        mismatches++;
        close_out;
    end
endmodule
`default_nettype wire
